// ---- design/chgmr_top.sv ----
// charger mode register, input current limit register and interrupt request
// assumes: an smbus front end on the link clock delivers each decoded
// write-word as a one-cycle strobe with command and data; status pins are
// asynchronous; the interrupt wire is resolved outside from its enable
//
// Notes on behaviour
// - Write-word with command 0x3F loads the 16-bit input limit word.
// - Input limit ignores data bits 0 to 6 unless bits 7 to 12 are all zero; steps are 256 mA.
// - Input limit also ignores data bits 13 to 15.
// - Requests beyond range clamp the applied input limit to 11.004 A.
// - Any nonzero request up to 256 mA applies as 256 mA.
// - Reset leaves the input limit register at 0x0080, i.e. 256 mA.
// - Battery removal returns the input limit register to its reset value.
// - Mode bit 0 sets or clears the charge-stop latch; set turns charger off.
// - Only mode writes change the charge-stop latch.
// - Restore bit loads voltage 0x4B00, current 0x0080 unless bit 3 is set, clears hot and alarm.
// - Mode bit 3 zeroes charge current and voltage set points.
// - Mode bits 4 to 6 mask adapter, battery, mains-low change interrupts.
// - Relearn off, adapter above battery: adapter gate low, battery gate high.
// - Relearn off, adapter not above battery: adapter gate high, battery low.
// - Relearn on, adapter above battery: battery path selected, thermistor still sets the overtemperature latch.
// - Halt enable set lets the overtemperature latch turn the charger off.
// - Overtemperature latch clears on restore or when battery absent.
// - Interrupt request drives the open-drain pin low.
// - Changes of mains-low, battery or adapter status request an interrupt.
// - Halt enable returns to one whenever the battery is removed.
// - Status bit 0 shows the charge-stop latch.
`timescale 1ns/1ns
`include "chgmr_consts.svh"

module chgmr_top
  import chgmr_pkg::*;
(
  input wire logic CORE_CLK_I, // core clock, 125 MHz
  input wire logic SRST_I, // core synchronous reset, active high
  input wire logic LINK_CLK_I, // clock of the smbus front end
  input wire logic LINK_SRST_I, // link synchronous reset, active high
  input wire logic LINK_WR_I, // one-cycle strobe: decoded write-word
  input wire logic [7:0] LINK_CMD_I, // command code of the write-word
  input wire logic [15:0] LINK_DATA_I, // data word of the write-word
  input wire logic ADAPTER_IN_I, // adapter present level, async
  input wire logic BATTERY_PRESENT_I, // battery present level, async
  input wire logic MAINS_LOW_I, // mains low level, async
  input wire logic OVERTEMP_DETECT_I, // overtemperature detect level, async
  input wire logic ADAPTER_ABOVE_BATTERY_NODE_I, // adapter 100 mV above battery, async
  input wire logic ALARM_SET_I, // alarm halt set pulse, core clock
  input wire logic INT_ACK_I, // interrupt served pulse, core clock
  input wire logic INT_N_I, // sensed level of the interrupt wire
  output logic INT_N_O, // interrupt pin output value
  output logic INT_N_OE_N_O, // interrupt pin enable, low pulls the wire
  output logic ADAPTER_PATH_GATE_O, // adapter path gate level
  output logic BATTERY_PATH_GATE_O, // battery path gate level
  output logic CHARGER_OFF_O, // high stops the switching regulator
  output logic [15:0] INPUT_LIMIT_O, // input limit register word
  output logic [15:0] INPUT_LIMIT_MA_O, // applied input limit in mA
  output logic [15:0] CHARGE_CURRENT_SETPOINT_O, // charge current register
  output logic [15:0] CHARGE_VOLTAGE_SETPOINT_O, // charge voltage register
  output logic [15:0] STATUS_WORD_O // status word as far as held here
);

  ////////////////////////////////////////////////////////////////////////////
  // input limit arithmetic

  // applied limit in mA from the register word
  function automatic logic [15:0] icl_to_ma(input logic [15:0] w);
    logic [15:0] ma;
    ma = {2'b00, w[`CHGMR_ICL_CODE_MSB:`CHGMR_ICL_CODE_LSB], 8'h00};
    if (w[`CHGMR_ICL_CODE_MSB:`CHGMR_ICL_CODE_LSB] == 6'h00) begin
      ma = (w[`CHGMR_ICL_CODE_LSB-1:0] != 7'h00) ? `CHGMR_ICL_STEP_MA : 16'h0000;
    end
    if (ma > `CHGMR_ICL_MAX_MA) begin
      ma = `CHGMR_ICL_MAX_MA;
    end
    return ma;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: capture the write-word and flip a toggle

  chgmr_link_state_type lq;
  chgmr_link_state_type next_lq;

  // hold command and data stable until the next write-word
  always_comb begin
    next_lq = lq;
    if (LINK_WR_I) begin
      next_lq.tog = ~lq.tog;
      next_lq.cmd = LINK_CMD_I;
      next_lq.data = LINK_DATA_I;
    end
    if (LINK_SRST_I) begin
      next_lq = '0;
    end
  end

  // link state register
  always_ff @(posedge LINK_CLK_I) begin
    lq <= next_lq;
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain

  chgmr_core_state_type q;
  chgmr_core_state_type next_q;
  logic wr_ev;
  logic mode_wr;
  logic icl_wr;
  logic removal;
  logic [2:0] changed;
  logic [15:0] wd;

  // write events, battery removal and status edges
  always_comb begin
    wr_ev = q.tog_sync[1] ^ q.tog_sync[2];
    wd = lq.data; // stable: the toggle settled two edges before
    mode_wr = wr_ev && (lq.cmd == `CHGMR_CMD_MODE);
    icl_wr = wr_ev && (lq.cmd == `CHGMR_CMD_INPUT_LIMIT);
    removal = q.pin_prev[`CHGMR_PIN_BATTERY] && !q.pin_s2[`CHGMR_PIN_BATTERY];
    changed[0] = q.pin_prev[`CHGMR_PIN_ADAPTER] ^ q.pin_s2[`CHGMR_PIN_ADAPTER];
    changed[1] = q.pin_prev[`CHGMR_PIN_BATTERY] ^ q.pin_s2[`CHGMR_PIN_BATTERY];
    changed[2] = q.pin_prev[`CHGMR_PIN_MAINS] ^ q.pin_s2[`CHGMR_PIN_MAINS];
  end

  // next core state
  always_comb begin
    next_q = q;
    next_q.tog_sync = {q.tog_sync[1:0], lq.tog};
    next_q.pin_s1 = {ADAPTER_ABOVE_BATTERY_NODE_I, OVERTEMP_DETECT_I, MAINS_LOW_I,
                     BATTERY_PRESENT_I, ADAPTER_IN_I};
    next_q.pin_s2 = q.pin_s1;
    next_q.pin_prev = q.pin_s2;
    // input limit register; removal takes precedence over a write
    if (icl_wr) begin
      next_q.icl = wd;
    end
    if (removal) begin
      next_q.icl = `CHGMR_ICL_POR;
      next_q.cc = `CHGMR_CC_POR;
      next_q.cv = `CHGMR_CV_POR;
      next_q.halt_en = 1'b1;
    end
    // mode write; bits 1, 7, 9 and 11 to 15 are not looked at
    if (mode_wr) begin
      next_q.stop = wd[`CHGMR_MODE_STOP];
      next_q.mask = wd[`CHGMR_MODE_MASK_LSB+:3];
      next_q.relearn = wd[`CHGMR_MODE_RELEARN];
      next_q.halt_en = wd[`CHGMR_MODE_HALT_EN] | removal;
      if (wd[`CHGMR_MODE_RESTORE]) begin
        next_q.cc = `CHGMR_CC_POR;
        next_q.cv = `CHGMR_CV_POR;
        next_q.ot_latch = 1'b0;
        next_q.alarm_latch = 1'b0;
      end
      if (wd[`CHGMR_MODE_ZERO]) begin
        next_q.cc = 16'h0000;
        next_q.cv = 16'h0000;
      end
    end
    // latches: clear by absent battery, set wins over any clear
    if (!q.pin_s2[`CHGMR_PIN_BATTERY]) begin
      next_q.ot_latch = 1'b0;
      next_q.alarm_latch = 1'b0;
    end
    if (q.pin_s2[`CHGMR_PIN_HOT]) begin
      next_q.ot_latch = 1'b1;
    end
    if (ALARM_SET_I) begin
      next_q.alarm_latch = 1'b1;
    end
    // interrupt request: acknowledge clears, an unmasked change wins
    if (INT_ACK_I) begin
      next_q.int_oe_n = 1'b1;
    end
    if ((changed & ~q.mask) != 3'b000) begin
      next_q.int_oe_n = 1'b0;
    end
    next_q.icl_ma = icl_to_ma(next_q.icl);
    // power path selection
    next_q.adapter_gate = !(q.pin_s2[`CHGMR_PIN_ABOVE] && !q.relearn);
    next_q.battery_gate = q.pin_s2[`CHGMR_PIN_ABOVE] && !q.relearn;
    next_q.charger_off = next_q.stop || next_q.alarm_latch ||
                         (next_q.halt_en && next_q.ot_latch);
    // status word
    next_q.status = 16'h0000;
    next_q.status[`CHGMR_ST_STOP] = next_q.stop;
    next_q.status[`CHGMR_ST_LEVEL2] = 1'b1;
    next_q.status[`CHGMR_ST_OVERTEMP] = next_q.ot_latch;
    next_q.status[`CHGMR_ST_ALARM] = next_q.alarm_latch;
    next_q.status[`CHGMR_ST_MAINS_LOW] = q.pin_s2[`CHGMR_PIN_MAINS];
    next_q.status[`CHGMR_ST_BATTERY] = q.pin_s2[`CHGMR_PIN_BATTERY];
    next_q.status[`CHGMR_ST_ADAPTER] = q.pin_s2[`CHGMR_PIN_ADAPTER];
    // reset values
    if (SRST_I) begin
      next_q = '0;
      next_q.icl = `CHGMR_ICL_POR;
      next_q.icl_ma = `CHGMR_ICL_STEP_MA;
      next_q.cc = `CHGMR_CC_POR;
      next_q.cv = `CHGMR_CV_POR;
      next_q.halt_en = 1'b1;
      next_q.int_oe_n = 1'b1;
      next_q.adapter_gate = 1'b1;
      next_q.status[`CHGMR_ST_LEVEL2] = 1'b1;
    end
  end

  // core state register
  always_ff @(posedge CORE_CLK_I) begin
    q <= next_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each but INT_N_O straight from the state register

  assign INT_N_O = 1'b0; // open drain only ever pulls low
  assign INT_N_OE_N_O = q.int_oe_n;
  assign ADAPTER_PATH_GATE_O = q.adapter_gate;
  assign BATTERY_PATH_GATE_O = q.battery_gate;
  assign CHARGER_OFF_O = q.charger_off;
  assign INPUT_LIMIT_O = q.icl;
  assign INPUT_LIMIT_MA_O = q.icl_ma;
  assign CHARGE_CURRENT_SETPOINT_O = q.cc;
  assign CHARGE_VOLTAGE_SETPOINT_O = q.cv;
  assign STATUS_WORD_O = q.status;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the core clock

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);

  // reset leaves the documented input limit
  AST_ICL_POR: assert property (disable iff (1'b0)
    SRST_I |=> (INPUT_LIMIT_O == `CHGMR_ICL_POR) && (INPUT_LIMIT_MA_O == 16'h0100))
    else $error("input limit not at reset value after reset");

  // an input limit write lands in the register on the next edge
  AST_ICL_WRITE: assert property (
    (icl_wr && !removal) |=> INPUT_LIMIT_O == $past(wd))
    else $error("input limit write not stored");

  // applied limit is a whole 256 mA step or the clamp value
  AST_ICL_STEP: assert property (
    (INPUT_LIMIT_MA_O[7:0] == 8'h00) || (INPUT_LIMIT_MA_O == 16'h2AFC))
    else $error("applied input limit off the 256 mA grid");

  // top bits of the word never change the applied limit
  AST_ICL_TOPBITS: assert property (
    $stable(INPUT_LIMIT_O[12:0]) |-> $stable(INPUT_LIMIT_MA_O))
    else $error("ignored input limit bits moved the applied limit");

  // applied limit never exceeds the clamp, and reaches it when overrange
  AST_ICL_CLAMP: assert property (
    (INPUT_LIMIT_MA_O <= 16'h2AFC) &&
    ((INPUT_LIMIT_O[12:7] < 6'h2B) || (INPUT_LIMIT_MA_O == 16'h2AFC)))
    else $error("input limit clamp broken");

  // a small nonzero request applies as one step
  AST_ICL_MIN: assert property (
    (INPUT_LIMIT_O[12:7] == 6'h00 && INPUT_LIMIT_O[6:0] != 7'h00)
      |-> INPUT_LIMIT_MA_O == 16'h0100)
    else $error("small input limit request not raised to 256 mA");

  // battery removal restores input limit and halt enable
  AST_REMOVAL: assert property (
    removal |=> (INPUT_LIMIT_O == `CHGMR_ICL_POR) && q.halt_en
      && (STATUS_WORD_O[`CHGMR_ST_OVERTEMP] == $past(q.pin_s2[`CHGMR_PIN_HOT])))
    else $error("battery removal did not restore defaults");

  // mode bit 0 reaches the latch, status bit 0 and the off output
  AST_STOP_SET: assert property (
    mode_wr |=> (STATUS_WORD_O[0] == $past(wd[0])) && ($past(wd[0]) -> CHARGER_OFF_O))
    else $error("charge-stop latch not written by mode bit 0");

  // nothing else moves the charge-stop latch
  AST_STOP_HOLD: assert property (
    !mode_wr |=> $stable(STATUS_WORD_O[0]))
    else $error("charge-stop latch moved without a mode write");

  // restore loads the charge set point defaults
  AST_RESTORE: assert property (
    (mode_wr && wd[2] && !wd[3]) |=>
      (CHARGE_CURRENT_SETPOINT_O == 16'h0080) && (CHARGE_VOLTAGE_SETPOINT_O == 16'h4B00))
    else $error("restore did not load set point defaults");

  // zero bit clears both set points, whatever restore bit 2 says
  AST_ZERO: assert property (
    (mode_wr && wd[3]) |=>
      (CHARGE_CURRENT_SETPOINT_O == 16'h0000) && (CHARGE_VOLTAGE_SETPOINT_O == 16'h0000))
    else $error("zero bit did not clear set points");

  // masked changes never pull the wire on their own
  AST_MASK: assert property (
    ((changed & ~q.mask) == 3'b000 && INT_N_OE_N_O) |=> INT_N_OE_N_O)
    else $error("interrupt raised by a masked change");

  // unmasked change pulls the wire low and it stays until acknowledged
  AST_INT_RAISE: assert property (
    ((changed & ~q.mask) != 3'b000) |=> !INT_N_OE_N_O && !INT_N_O
      ##1 (!INT_N_OE_N_O || $past(INT_ACK_I)))
    else $error("interrupt request not raised or dropped early");

  // pulling the open-drain pin always drives zero
  AST_INT_LOW: assert property (
    !INT_N_OE_N_O |-> INT_N_O == 1'b0)
    else $error("interrupt pin driven high");

  // path gates follow the comparator and relearn select one edge later
  AST_GATES: assert property (
    (BATTERY_PATH_GATE_O == !ADAPTER_PATH_GATE_O) &&
    (BATTERY_PATH_GATE_O == $past(q.pin_s2[`CHGMR_PIN_ABOVE] && !q.relearn)))
    else $error("power path gates wrong");

  // relearn select forces the battery path
  AST_RELEARN: assert property (
    q.relearn |=> ADAPTER_PATH_GATE_O && !BATTERY_PATH_GATE_O)
    else $error("relearn did not select the battery path");

  // hot battery with halt enabled stops the charger
  AST_HALT: assert property (
    (q.halt_en && q.ot_latch) |-> CHARGER_OFF_O)
    else $error("overtemperature halt ignored");

  // overtemperature latch drops while the battery is absent
  AST_OT_CLEAR: assert property (
    (!q.pin_s2[`CHGMR_PIN_BATTERY] && !q.pin_s2[`CHGMR_PIN_HOT]) |=> !STATUS_WORD_O[10])
    else $error("overtemperature latch not cleared");

  // acknowledge with no new change releases the wire
  AST_INT_ACK: assert property (
    (INT_ACK_I && (changed & ~q.mask) == 3'b000) |=> INT_N_OE_N_O)
    else $error("interrupt request not released by acknowledge");

  // restore clears the overtemperature and alarm latches
  AST_RESTORE_CLEAR: assert property (
    (mode_wr && wd[`CHGMR_MODE_RESTORE] && !q.pin_s2[`CHGMR_PIN_HOT] && !ALARM_SET_I)
      |=> !STATUS_WORD_O[`CHGMR_ST_OVERTEMP] && !STATUS_WORD_O[`CHGMR_ST_ALARM])
    else $error("restore did not clear the halt latches");

  // a mode write takes masks, relearn select and halt enable
  AST_MODE_FIELDS: assert property (
    (mode_wr && !removal) |=> (q.mask == $past(wd[6:4])) && (q.relearn == $past(wd[8]))
      && (q.halt_en == $past(wd[10])))
    else $error("mode fields not taken");

  // reset leaves the mode bits at zero and halt enable at one
  AST_MODE_POR: assert property (disable iff (1'b0)
    SRST_I |=> q.halt_en && !q.stop && !q.relearn && (q.mask == 3'b000))
    else $error("mode bits not at reset values after reset");

  // adapter not above battery selects the battery path
  AST_GATES_LOW: assert property (
    !q.pin_s2[`CHGMR_PIN_ABOVE] |=> ADAPTER_PATH_GATE_O && !BATTERY_PATH_GATE_O)
    else $error("battery path not selected with adapter low");

  // with halt disabled and no latch set the charger keeps running
  AST_OFF_CAUSE: assert property (
    (!q.halt_en && !q.stop && !q.alarm_latch) |-> !CHARGER_OFF_O)
    else $error("charger off without a cause");

  // status bits 13 to 15 follow the synchronised pins
  AST_STATUS_PINS: assert property (
    STATUS_WORD_O[15:13] == $past({q.pin_s2[`CHGMR_PIN_ADAPTER],
      q.pin_s2[`CHGMR_PIN_BATTERY], q.pin_s2[`CHGMR_PIN_MAINS]}))
    else $error("status pin bits wrong");

  // unimplemented mode bits leave the charge set points alone
  AST_MODE_UNUSED: assert property (
    (mode_wr && !removal && !wd[`CHGMR_MODE_RESTORE] && !wd[`CHGMR_MODE_ZERO])
      |=> $stable(CHARGE_CURRENT_SETPOINT_O) && $stable(CHARGE_VOLTAGE_SETPOINT_O))
    else $error("mode write moved the set points");

  // scenarios worth seeing
  CVR_ICL_OVER: cover property (icl_wr && wd[12:7] == 6'h3F);
  CVR_RESTORE_ZERO: cover property (mode_wr && wd[2] && wd[3]);
  CVR_INT_ACK: cover property (!INT_N_OE_N_O ##1 INT_ACK_I ##1 INT_N_OE_N_O);
  CVR_REMOVAL_WRITE: cover property (removal && icl_wr);
  CVR_HOT_HALT: cover property (q.halt_en && q.ot_latch ##1 CHARGER_OFF_O);

endmodule

// ---- design/chgmr_consts.svh ----
// constants of the charger mode and input limit register bank
// assumes: nothing; needs no import of chgmr_pkg and is included ahead of it
`ifndef CHGMR_CONSTS_SVH
`define CHGMR_CONSTS_SVH
// command codes of the two write-word registers
`define CHGMR_CMD_MODE 8'h12
`define CHGMR_CMD_INPUT_LIMIT 8'h3F
// power-on values
`define CHGMR_ICL_POR 16'h0080
`define CHGMR_CC_POR 16'h0080
`define CHGMR_CV_POR 16'h4B00
// input limit arithmetic: step and clamp in milliamps, code field bit positions
`define CHGMR_ICL_STEP_MA 16'h0100
`define CHGMR_ICL_MAX_MA 16'h2AFC
`define CHGMR_ICL_CODE_MSB 12
`define CHGMR_ICL_CODE_LSB 7
// mode word field positions
`define CHGMR_MODE_STOP 0
`define CHGMR_MODE_RESTORE 2
`define CHGMR_MODE_ZERO 3
`define CHGMR_MODE_MASK_LSB 4
`define CHGMR_MODE_RELEARN 8
`define CHGMR_MODE_HALT_EN 10
// status word field positions
`define CHGMR_ST_STOP 0
`define CHGMR_ST_LEVEL2 4
`define CHGMR_ST_OVERTEMP 10
`define CHGMR_ST_ALARM 12
`define CHGMR_ST_MAINS_LOW 13
`define CHGMR_ST_BATTERY 14
`define CHGMR_ST_ADAPTER 15
// index of each status pin inside the pin vector
`define CHGMR_PIN_ADAPTER 0
`define CHGMR_PIN_BATTERY 1
`define CHGMR_PIN_MAINS 2
`define CHGMR_PIN_HOT 3
`define CHGMR_PIN_ABOVE 4
`endif

// ---- design/chgmr_pkg.sv ----
// types of the charger mode and input limit register bank
// assumes: nothing beyond a SystemVerilog compiler
package chgmr_pkg;

  // state kept on the link clock
  typedef struct packed {
    logic tog;
    logic [7:0] cmd;
    logic [15:0] data;
  } chgmr_link_state_type;

  // state kept on the core clock
  typedef struct packed {
    logic [2:0] tog_sync;
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] pin_prev;
    logic [15:0] icl;
    logic [15:0] icl_ma;
    logic [15:0] cc;
    logic [15:0] cv;
    logic stop;
    logic [2:0] mask;
    logic relearn;
    logic halt_en;
    logic ot_latch;
    logic alarm_latch;
    logic int_oe_n;
    logic adapter_gate;
    logic battery_gate;
    logic charger_off;
    logic [15:0] status;
  } chgmr_core_state_type;

endpackage

// ---- tb/chgmr_host_model.sv ----
// smbus host model: hands decoded write-words over on its own link clock
// assumes: the register bank samples the strobe on the rising link edge
`timescale 1ns/1ns
module chgmr_host_model (
  output logic LINK_CLK_O, // link clock, stands still between words
  output logic LINK_SRST_O, // link reset, active high
  output logic LINK_WR_O, // write-word strobe
  output logic [7:0] LINK_CMD_O, // command code
  output logic [15:0] LINK_DATA_O // data word
);
  ////////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial begin
    LINK_CLK_O = 1'b0;
    LINK_SRST_O = 1'b1;
    LINK_WR_O = 1'b0;
    LINK_CMD_O = 8'h00;
    LINK_DATA_O = 16'h0000;
  end
  // one link period, rising edge first, 48 ns
  task automatic link_cycle();
    LINK_CLK_O = 1'b1;
    #24;
    LINK_CLK_O = 1'b0;
    #24;
  endtask
  // link reset held over three edges, one more edge before the first word
  task automatic reset_link();
    repeat (3) link_cycle();
    LINK_SRST_O = 1'b0;
    link_cycle();
  endtask
  // one word: qualifiers set after a rising edge and held to the next one
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
    #3;
    LINK_CLK_O = 1'b1;
    #1;
    LINK_WR_O = 1'b1;
    LINK_CMD_O = cmd;
    LINK_DATA_O = data;
    #23;
    LINK_CLK_O = 1'b0;
    #24;
    LINK_CLK_O = 1'b1;
    #1;
    LINK_WR_O = 1'b0;
    // released lines show no stale value
    LINK_CMD_O = ~cmd;
    LINK_DATA_O = ~data;
    #23;
    LINK_CLK_O = 1'b0;
    #24;
    repeat (2) link_cycle();
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench of the charger mode and input limit register bank
// assumes: host model compiled first, design header on the include path
`timescale 1ns/1ns
`include "chgmr_consts.svh"
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic alarm = 1'b0;
  logic ack = 1'b0;
  logic hot = 1'b0;
  logic above = 1'b0;
  logic [2:0] pins = 3'b000; // adapter, battery, mains low
  logic lclk, lsrst, lwr, int_o, oe_n, ga, gb, off;
  logic [7:0] lcmd;
  logic [15:0] ldata, icl, ma, cc, cv, st, d;
  logic [15:0] tab [9] = '{16'h0000, 16'h0001, 16'h0080, 16'h00FF, 16'hE100,
    16'h1500, 16'h1580, 16'h2AFC, 16'hFFFF};
  wire int_wire = oe_n ? 1'b1 : int_o; // pull-up on the open-drain wire
  integer fail_count = 0;
  integer check_count = 0;
  integer seed = 32'h3b4a;
  ////////////////////////////////////////////////////////////////////////
  // core clock, 8 ns
  always #4 clk = ~clk;
  chgmr_host_model i_chgmr_host_model (.LINK_CLK_O(lclk), .LINK_SRST_O(lsrst),
    .LINK_WR_O(lwr), .LINK_CMD_O(lcmd), .LINK_DATA_O(ldata));
  chgmr_top i_chgmr_top (.CORE_CLK_I(clk), .SRST_I(srst), .LINK_CLK_I(lclk),
    .LINK_SRST_I(lsrst), .LINK_WR_I(lwr), .LINK_CMD_I(lcmd), .LINK_DATA_I(ldata),
    .ADAPTER_IN_I(pins[0]), .BATTERY_PRESENT_I(pins[1]), .MAINS_LOW_I(pins[2]),
    .OVERTEMP_DETECT_I(hot), .ADAPTER_ABOVE_BATTERY_NODE_I(above), .ALARM_SET_I(alarm),
    .INT_ACK_I(ack), .INT_N_I(int_wire), .INT_N_O(int_o), .INT_N_OE_N_O(oe_n),
    .ADAPTER_PATH_GATE_O(ga), .BATTERY_PATH_GATE_O(gb), .CHARGER_OFF_O(off),
    .INPUT_LIMIT_O(icl), .INPUT_LIMIT_MA_O(ma), .CHARGE_CURRENT_SETPOINT_O(cc),
    .CHARGE_VOLTAGE_SETPOINT_O(cv), .STATUS_WORD_O(st));
  ////////////////////////////////////////////////////////////////////////
  // applied limit in mA from a written word
  function automatic logic [15:0] exp_ma(input logic [15:0] v);
    logic [15:0] m;
    m = {2'b00, v[12:7], 8'h00};
    if (v[12:7] == 6'h00 && v[6:0] != 7'h00) m = 16'h0100;
    if (m > 16'h2AFC) m = 16'h2AFC;
    return m;
  endfunction
  // compare and count
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one write-word, then let the sync land
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    i_chgmr_host_model.write_word(c, v);
    wt(3);
  endtask
  task automatic pin(input int i, input logic v);
    pins[i] = v;
    wt(6);
  endtask
  task automatic serve();
    ack = 1'b1;
    wt(1);
    ack = 1'b0;
    wt(1);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  // main sequence
  initial begin
    fork
      i_chgmr_host_model.reset_link();
      begin
        wt(20);
        srst = 1'b0;
      end
    join
    wt(4);
    chk("icl", 16'h0080, icl);
    chk("icl_ma", 16'h0100, ma);
    chk("status", 16'h0010, st);
    chk("off_int_gates", 16'h0006, {12'h000, off, oe_n, ga, gb});
    for (int k = 0; k < 15; k++) begin
      d = (k < 9) ? tab[k] : 16'($random(seed));
      wr(`CHGMR_CMD_INPUT_LIMIT, d);
      chk("icl", d, icl);
      chk("icl_ma", exp_ma(d), ma);
    end
    wr(`CHGMR_CMD_MODE, 16'h0001);
    chk("stop", 16'h0003, {14'h0000, off, st[0]});
    wr(`CHGMR_CMD_INPUT_LIMIT, 16'h0300);
    wr(8'h14, 16'h0000);
    chk("stop", 16'h0003, {14'h0000, off, st[0]});
    wr(`CHGMR_CMD_MODE, 16'h0008);
    chk("stop", 16'h0000, {14'h0000, off, st[0]});
    chk("cc", 16'h0000, cc);
    chk("cv", 16'h0000, cv);
    wr(`CHGMR_CMD_MODE, 16'h000C);
    chk("cc", 16'h0000, cc);
    chk("cv", 16'h0000, cv);
    wr(`CHGMR_CMD_MODE, 16'h0004);
    chk("cc", 16'h0080, cc);
    chk("cv", 16'h4B00, cv);
    wr(`CHGMR_CMD_MODE, 16'hFA83);
    chk("stop_cc", 16'h0101, {cc[14:0], st[0]});
    wr(`CHGMR_CMD_MODE, 16'h0000);
    chk("int", 16'h0001, {15'h0000, oe_n});
    // each status change raises a request unless masked
    for (int i = 0; i < 3; i++) begin
      pin(i, 1'b1);
      chk("int", 16'h0004, {13'h0000, st[15 - i], oe_n, int_wire});
      serve();
      chk("int", 16'h0003, {14'h0000, oe_n, int_wire});
      wr(`CHGMR_CMD_MODE, 16'h0010 << i);
      pin(i, 1'b0);
      chk("int", 16'h0003, {14'h0000, oe_n, int_wire});
    end
    chk("icl", 16'h0080, icl);
    // overtemperature and alarm halts, all changes masked
    wr(`CHGMR_CMD_MODE, 16'h0070);
    pin(1, 1'b1);
    hot = 1'b1;
    wt(6);
    chk("hot", 16'h0001, {14'h0000, off, st[10]});
    wr(`CHGMR_CMD_MODE, 16'h0470);
    chk("hot", 16'h0003, {14'h0000, off, st[10]});
    hot = 1'b0;
    alarm = 1'b1;
    wt(1);
    alarm = 1'b0;
    wt(4);
    chk("alarm", 16'h0003, {14'h0000, off, st[12]});
    wr(`CHGMR_CMD_MODE, 16'h0474);
    chk("restore", 16'h0000, {13'h0000, off, st[12], st[10]});
    wr(`CHGMR_CMD_MODE, 16'h0070);
    pin(1, 1'b0);
    pin(1, 1'b1);
    hot = 1'b1;
    wt(6);
    chk("halt", 16'h0003, {14'h0000, off, st[10]});
    hot = 1'b0;
    pin(1, 1'b0);
    chk("hot", 16'h0000, {14'h0000, off, st[10]});
    // path gates for every relearn, comparator and thermistor level
    for (int k = 0; k < 8; k++) begin
      above = k[0];
      hot = k[2];
      wr(`CHGMR_CMD_MODE, {7'h00, k[1], 8'h70});
      wt(3);
      d = {14'h0000, ~(above & ~k[1]), above & ~k[1]};
      chk("gates", d, {14'h0000, ga, gb});
    end
    complete_run();
  end
endmodule
